// file: rtl/fcs_regs.svh
// Instruction codes, status bit positions and serial framing constants.
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

// ========================================================
// Instruction bytes
`define FCS_OP_SUSPEND 8'h75
`define FCS_OP_SUSPEND_ALT1 8'h85
`define FCS_OP_SUSPEND_ALT2 8'hB0
`define FCS_OP_RESUME 8'h7A
`define FCS_OP_RESUME_ALT1 8'h8A
`define FCS_OP_RESUME_OR_CLEAR 8'h30
`define FCS_OP_CLEAR_STATUS 8'h82
`define FCS_OP_STATUS_READ 8'h05
`define FCS_OP_READ_ANY_REG 8'h65
`define FCS_OP_WRITE_ENABLE 8'h06
`define FCS_OP_WRITE_DISABLE 8'h04
`define FCS_OP_WRITE_REGS 8'h01
`define FCS_OP_SOFT_RESET_EN 8'h66
`define FCS_OP_SOFT_RESET 8'h99
`define FCS_OP_LEGACY_RESET 8'hF0
`define FCS_OP_ENTER_SLEEP 8'hB9
`define FCS_OP_RELEASE_SLEEP 8'hAB
`define FCS_OP_OTP_PROG 8'h42
`define FCS_OP_OTP_READ 8'h4B
`define FCS_OP_DYNP_RD 8'hFA
`define FCS_OP_DYNP_RD4 8'hE0
`define FCS_OP_DYNP_WR 8'hFB
`define FCS_OP_DYNP_WR4 8'hE1
`define FCS_OP_PERSP_RD 8'hFC
`define FCS_OP_PERSP_RD4 8'hE2
`define FCS_OP_PERSP_PROG 8'hFD
`define FCS_OP_PERSP_PROG4 8'hE3
`define FCS_OP_PERSP_ERASE 8'hE4
`define FCS_OP_SPROT_RD 8'h2B
`define FCS_OP_SPROT_PROG 8'h2F
`define FCS_OP_LOCK_RD 8'hA7
`define FCS_OP_LOCK_WR 8'hA6
`define FCS_OP_PASS_RD 8'hE7
`define FCS_OP_PASS_PROG 8'hE8
`define FCS_OP_PASS_UNLOCK 8'hE9

// ========================================================
// Volatile status one bit positions and framing
`define FCS_SR_BUSY 0
`define FCS_SR_WLATCH 1
`define FCS_SR_EERR 5
`define FCS_SR_PERR 6
`define FCS_LAST_BIT 3'h7
`define FCS_LAST_ADDR 2'h2
`define FCS_BYTE_ZERO 8'h00

`endif

// file: rtl/fcs_pkg.sv
// Types shared by the command and status block.
package fcs_pkg;

	// ========================================================
	// Serial frame phase.
	typedef enum logic [1:0] {PH_OPCODE, PH_ADDR, PH_DATA_OUT, PH_IGNORE
	} fcs_phase_t;

	// ========================================================
	// Class of a command handed to the array engine.
	typedef enum logic [3:0] {K_OTHER, K_SUSPEND, K_RESUME, K_OTP_PROG,
		K_OTP_READ, K_DYNP, K_PERSP, K_LOCK, K_SPROT, K_PASSWORD, K_REG_WRITE
	} fcs_kind_t;

	typedef struct packed {
		logic valid;
		fcs_kind_t kind;
		logic [7:0] code;
	} fcs_cmd_t;

	typedef struct packed {
		logic busy_flag;
		logic write_enable_latch;
		logic prog_err;
		logic erase_err;
		logic suspended;
		logic deep_power_down;
	} fcs_status_t;

endpackage

// file: rtl/fcs_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/100ps
module fcs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Asynchronous in, synchronous out.
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;

	// The first stage is read only by the second, to let metastability settle.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// file: rtl/fcs_ctrl.sv
// Serial command decode, suspend, error and power-down control.
//
// How it works
// - Bytes 75, 85 and B0 request suspend of a running erase or program.
// - Bytes 7A and 8A resume a suspended operation; no address follows.
// - Byte 30 resumes unless configured as clear-status or an error flag is set.
// - B9 enters deep power-down, AB leaves it.
// - Register writes start one automatic erase-and-program operation.
// - Busy flag reported via status read 05 or read-any-register 65.
// - Program or erase failure sets its own sticky error flag.
// - Any error flag forces busy and refuses most commands.
// - In error only 05, 65, 30, 82, 66, 99, F0 are accepted.
// - Clear-status clears errors, so busy again follows the engine; write-disable clears the latch.
// - Hardware or software reset also clears the error state.
// - Busy flag is status bit 0; zero means idle.
// - Power-down entered only when idle; then only AB is obeyed.
`timescale 1ns/100ps
`include "fcs_regs.svh"
module fcs_ctrl (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Serial link pins.
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Array engine handshake.
	input wire logic op_busy,
	input wire logic prog_fail,
	input wire logic erase_fail,
	input wire logic cfg_30_clear,
	output fcs_pkg::fcs_cmd_t cmd,
	// Status view.
	output fcs_pkg::fcs_status_t status
);
	logic s_sck, s_cs_n, s_si, sck_prev_q, rise, fall;
	logic [7:0] sh_q, opc, out_sh_q;
	logic [2:0] bit_q;
	logic [1:0] addr_q;
	logic byte_done, exec, err, accept, is_clear, is_resume, is_suspend;
	logic is_soft_reset, rst_arm_q, perr_q, eerr_q, busy_q, wlatch_q;
	logic susp_q, sleep_q, so_q, so_oe_q, local_op;
	fcs_pkg::fcs_phase_t phase_q;
	fcs_pkg::fcs_cmd_t cmd_q;

	// ========================================================
	// Pin sampling: SCK is slow enough to find its edges at mclk.
	fcs_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.din({cs_n, sck, si}),
		.dout({s_cs_n, s_sck, s_si})
	);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= s_sck;
		end
	end

	assign rise = s_sck & ~sck_prev_q & ~s_cs_n;
	assign fall = ~s_sck & sck_prev_q & ~s_cs_n;
	assign byte_done = rise && (bit_q == `FCS_LAST_BIT);
	assign opc = {sh_q[6:0], s_si};
	assign exec = byte_done && (phase_q == fcs_pkg::PH_OPCODE);

	// ========================================================
	// Command classes.
	function automatic fcs_pkg::fcs_kind_t kind_of(input logic [7:0] c);
		fcs_pkg::fcs_kind_t k;
		k = fcs_pkg::K_OTHER;
		case (c)
			`FCS_OP_OTP_PROG: k = fcs_pkg::K_OTP_PROG;
			`FCS_OP_OTP_READ: k = fcs_pkg::K_OTP_READ;
			`FCS_OP_DYNP_RD, `FCS_OP_DYNP_RD4, `FCS_OP_DYNP_WR,
			`FCS_OP_DYNP_WR4: k = fcs_pkg::K_DYNP;
			`FCS_OP_PERSP_RD, `FCS_OP_PERSP_RD4, `FCS_OP_PERSP_PROG,
			`FCS_OP_PERSP_PROG4,
			`FCS_OP_PERSP_ERASE: k = fcs_pkg::K_PERSP;
			`FCS_OP_LOCK_RD, `FCS_OP_LOCK_WR: k = fcs_pkg::K_LOCK;
			`FCS_OP_SPROT_RD, `FCS_OP_SPROT_PROG: k = fcs_pkg::K_SPROT;
			`FCS_OP_PASS_RD, `FCS_OP_PASS_PROG,
			`FCS_OP_PASS_UNLOCK: k = fcs_pkg::K_PASSWORD;
			`FCS_OP_WRITE_REGS: k = fcs_pkg::K_REG_WRITE;
			default: k = fcs_pkg::K_OTHER;
		endcase
		return k;
	endfunction

	// Byte 30 is clear-status when configured so or when in error.
	assign err = perr_q | eerr_q;
	assign is_clear = (opc == `FCS_OP_CLEAR_STATUS) ||
		((opc == `FCS_OP_RESUME_OR_CLEAR) && (cfg_30_clear || err));
	assign is_resume = (opc == `FCS_OP_RESUME) || (opc == `FCS_OP_RESUME_ALT1)
		|| ((opc == `FCS_OP_RESUME_OR_CLEAR) && !is_clear);
	assign is_suspend = (opc == `FCS_OP_SUSPEND) ||
		(opc == `FCS_OP_SUSPEND_ALT1) || (opc == `FCS_OP_SUSPEND_ALT2);
	assign is_soft_reset = (opc == `FCS_OP_LEGACY_RESET) ||
		((opc == `FCS_OP_SOFT_RESET) && rst_arm_q);

	// Power-down admits only release; the error state a short list.
	always_comb begin
		if (sleep_q) begin
			accept = (opc == `FCS_OP_RELEASE_SLEEP);
		end else if (err) begin
			accept = (opc == `FCS_OP_STATUS_READ) ||
				(opc == `FCS_OP_READ_ANY_REG) || is_clear ||
				(opc == `FCS_OP_SOFT_RESET_EN) ||
				(opc == `FCS_OP_SOFT_RESET) ||
				(opc == `FCS_OP_LEGACY_RESET);
		end else begin
			accept = 1'b1;
		end
	end

	// Ops handled here, other than suspend and resume, never reach the array engine.
	assign local_op = is_clear || (opc == `FCS_OP_STATUS_READ) ||
		(opc == `FCS_OP_READ_ANY_REG) || (opc == `FCS_OP_WRITE_ENABLE) ||
		(opc == `FCS_OP_WRITE_DISABLE) || (opc == `FCS_OP_SOFT_RESET_EN) ||
		(opc == `FCS_OP_SOFT_RESET) || (opc == `FCS_OP_LEGACY_RESET) ||
		(opc == `FCS_OP_ENTER_SLEEP) || (opc == `FCS_OP_RELEASE_SLEEP) ||
		is_suspend || is_resume;

	// ========================================================
	// Shift register and frame phase; CS high restarts the frame.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sh_q <= `FCS_BYTE_ZERO;
			bit_q <= '0;
			addr_q <= '0;
			phase_q <= fcs_pkg::PH_OPCODE;
		end else if (s_cs_n) begin
			bit_q <= '0;
			addr_q <= '0;
			phase_q <= fcs_pkg::PH_OPCODE;
		end else if (rise) begin
			sh_q <= opc;
			bit_q <= bit_q + 3'h1;
			if (byte_done) begin
				unique case (phase_q)
					fcs_pkg::PH_OPCODE: begin
						if (accept && opc == `FCS_OP_STATUS_READ) begin
							phase_q <= fcs_pkg::PH_DATA_OUT;
						end else if (accept && opc == `FCS_OP_READ_ANY_REG) begin
							phase_q <= fcs_pkg::PH_ADDR;
						end else begin
							phase_q <= fcs_pkg::PH_IGNORE;
						end
					end
					fcs_pkg::PH_ADDR: begin
						addr_q <= addr_q + 2'h1;
						if (addr_q == `FCS_LAST_ADDR) begin
							phase_q <= fcs_pkg::PH_DATA_OUT;
						end
					end
					fcs_pkg::PH_DATA_OUT: phase_q <= fcs_pkg::PH_DATA_OUT;
					fcs_pkg::PH_IGNORE: phase_q <= fcs_pkg::PH_IGNORE;
				endcase
			end
		end
	end

	// ========================================================
	// Error flags: a failure in the clearing cycle still sets the flag.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			perr_q <= 1'b0;
			eerr_q <= 1'b0;
		end else begin
			if (exec && accept && (is_clear || is_soft_reset)) begin
				perr_q <= 1'b0;
				eerr_q <= 1'b0;
			end
			if (prog_fail) begin
				perr_q <= 1'b1;
			end
			if (erase_fail) begin
				eerr_q <= 1'b1;
			end
		end
	end

	// Busy follows the engine, held high by any error flag.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= op_busy | perr_q | eerr_q;
		end
	end

	// Write-enable latch; write-disable is refused until errors clear.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wlatch_q <= 1'b0;
		end else if (exec && accept) begin
			if (opc == `FCS_OP_WRITE_ENABLE) begin
				wlatch_q <= 1'b1;
			end else if (opc == `FCS_OP_WRITE_DISABLE || is_soft_reset) begin
				wlatch_q <= 1'b0;
			end
		end
	end

	// Reset-enable arms only the very next instruction.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_arm_q <= 1'b0;
		end else if (exec) begin
			rst_arm_q <= accept && (opc == `FCS_OP_SOFT_RESET_EN);
		end
	end

	// Suspend state and deep power-down.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			susp_q <= 1'b0;
			sleep_q <= 1'b0;
		end else if (exec && accept) begin
			if (is_suspend && op_busy) begin
				susp_q <= 1'b1;
			end else if (is_resume || is_soft_reset) begin
				susp_q <= 1'b0;
			end
			if (opc == `FCS_OP_ENTER_SLEEP && !busy_q) begin
				sleep_q <= 1'b1;
			end else if (opc == `FCS_OP_RELEASE_SLEEP) begin
				sleep_q <= 1'b0;
			end
		end
	end

	// Commands for the array engine, one mclk pulse each.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_q <= '0;
		end else begin
			cmd_q.valid <= 1'b0;
			if (exec && accept) begin
				cmd_q.code <= opc;
				if (is_suspend) begin
					cmd_q.valid <= op_busy && !susp_q;
					cmd_q.kind <= fcs_pkg::K_SUSPEND;
				end else if (is_resume) begin
					cmd_q.valid <= susp_q;
					cmd_q.kind <= fcs_pkg::K_RESUME;
				end else begin
					cmd_q.valid <= !local_op;
					cmd_q.kind <= kind_of(opc);
				end
			end
		end
	end

	// ========================================================
	// Status byte out, MSB first on SCK falls; it repeats while CS stays low.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			out_sh_q <= `FCS_BYTE_ZERO;
			so_q <= 1'b0;
			so_oe_q <= 1'b0;
		end else begin
			so_oe_q <= !s_cs_n && (phase_q == fcs_pkg::PH_DATA_OUT);
			if (byte_done && phase_q != fcs_pkg::PH_DATA_OUT) begin
				out_sh_q <= `FCS_BYTE_ZERO;
				out_sh_q[`FCS_SR_BUSY] <= busy_q;
				out_sh_q[`FCS_SR_WLATCH] <= wlatch_q;
				out_sh_q[`FCS_SR_EERR] <= eerr_q;
				out_sh_q[`FCS_SR_PERR] <= perr_q;
			end else if (fall && phase_q == fcs_pkg::PH_DATA_OUT) begin
				so_q <= out_sh_q[7];
				out_sh_q <= {out_sh_q[6:0], out_sh_q[7]};
			end
		end
	end

	assign so = so_q;
	assign so_oe = so_oe_q;
	assign cmd = cmd_q;
	assign status = '{busy_flag: busy_q, write_enable_latch: wlatch_q,
		prog_err: perr_q, erase_err: eerr_q, suspended: susp_q,
		deep_power_down: sleep_q};

	// ========================================================
	// Checks.
	busy_in_err_a: assert property (@(posedge mclk)
		disable iff (!reset_n) err |=> busy_q)
		else $error("busy low with error set");
	err_set_a: assert property (@(posedge mclk)
		disable iff (!reset_n) prog_fail |=> perr_q)
		else $error("program error not set");
	erase_set_a: assert property (@(posedge mclk)
		disable iff (!reset_n) erase_fail |=> eerr_q)
		else $error("erase error not set");
	// Only a taken clear or software reset may drop a set error flag.
	err_sticky_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		err && !(exec && accept && (is_clear || is_soft_reset)) |=> err)
		else $error("error flag not held");
	sleep_hold_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		sleep_q && exec && opc != `FCS_OP_RELEASE_SLEEP |=> sleep_q)
		else $error("power-down left without release");
	sleep_busy_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		!sleep_q && busy_q && exec && opc == `FCS_OP_ENTER_SLEEP
		|=> !sleep_q) else $error("power-down entered while busy");
	clear_err_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		exec && accept && is_clear && !prog_fail && !erase_fail
		|=> !perr_q && !eerr_q ##1 busy_q == $past(op_busy))
		else $error("clear-status failed");
	err_refuse_a: assert property (@(posedge mclk)
		disable iff (!reset_n) err && exec &&
		(opc == `FCS_OP_WRITE_ENABLE || opc == `FCS_OP_WRITE_DISABLE)
		|=> $stable(wlatch_q) && !cmd_q.valid)
		else $error("command taken in error");
	suspend_go_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		exec && accept && is_suspend && op_busy && !susp_q
		|=> susp_q && cmd_q.valid && cmd_q.kind == fcs_pkg::K_SUSPEND)
		else $error("suspend not issued");
	resume_go_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		exec && accept && is_resume && susp_q
		|=> !susp_q && cmd_q.valid && cmd_q.kind == fcs_pkg::K_RESUME)
		else $error("resume not issued");
	soft_reset_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		exec && accept && is_soft_reset && !prog_fail && !erase_fail
		|=> !err && !wlatch_q && !susp_q)
		else $error("software reset left error state");
	reg_write_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		exec && !sleep_q && !err && opc == `FCS_OP_WRITE_REGS
		|=> cmd_q.valid && cmd_q.kind == fcs_pkg::K_REG_WRITE)
		else $error("register write not started");
	status_bit_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		exec && accept && opc == `FCS_OP_STATUS_READ
		|=> out_sh_q[`FCS_SR_BUSY] == $past(busy_q))
		else $error("busy bit not loaded");
endmodule

// file: bench/fcs_host.sv
// Host-side serial controller model that frames commands in mode 0.
`timescale 1ns/100ps
module fcs_host (
	// Clock used only to pick a start point and the end gap of each frame.
	mclk,
	// Serial link pins.
	sck,
	cs_n,
	si,
	so,
	so_oe
);
	input wire logic mclk;
	output logic sck;
	output logic cs_n;
	output logic si;
	input wire logic so;
	input wire logic so_oe;

	// ========================================================
	// Link timing
	// Half period of the 125 ns serial clock.
	localparam realtime HALF = 62.5;

	// Link idles with the clock low and the device deselected.
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// Sends one opcode and nadr zero bytes, then reads nrd bytes.
	// Only single-wire commands are ever sent.
	// A data bit read while the output is not enabled becomes unknown,
	// so a stale level on the pin can never pass as a match.
	task automatic xfer(input logic [7:0] op, input int nadr,
		input int nrd, output logic [7:0] rd);
		logic [7:0] sh;
		rd = 8'h00;
		@(posedge mclk);
		#1 cs_n = 1'b0;
		for (int b = 0; b < 8 * (1 + nadr + nrd); b++) begin
			sh = (b < 8) ? op : 8'h00;
			si = sh[7 - (b % 8)];
			#HALF sck = 1'b1;
			if (b >= 8 * (1 + nadr)) begin
				rd = {rd[6:0], (so_oe === 1'b1) ? so : 1'bx};
			end
			#HALF sck = 1'b0;
		end
		#HALF cs_n = 1'b1;
		// A released data line must not keep showing the last bit.
		si = ~si;
		repeat (5) @(posedge mclk);
	endtask
endmodule

// file: bench/test_fcs_ctrl.sv
// Self-checking bench for the command decode and status block.
`timescale 1ns/100ps
`define TB_CHECK(nm, e, g) begin check_count++; \
	if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_fcs_ctrl;
	logic mclk, reset_n, op_busy, prog_fail, erase_fail, cfg_30_clear;
	logic sck, cs_n, si, so, so_oe;
	fcs_pkg::fcs_cmd_t cmd;
	fcs_pkg::fcs_status_t status;
	int num_errors, check_count, n_cmd;
	logic [7:0] rd, last_code;
	logic [3:0] last_kind;
	localparam logic [7:0] SUS [3] = '{8'h75, 8'h85, 8'hB0};
	localparam logic [7:0] RSM [3] = '{8'h7A, 8'h8A, 8'h30};
	// Engine-bound opcodes with the class each must carry.
	localparam logic [11:0] PT [19] = '{{8'h01, fcs_pkg::K_REG_WRITE},
		{8'h42, fcs_pkg::K_OTP_PROG}, {8'h4B, fcs_pkg::K_OTP_READ},
		{8'hFA, fcs_pkg::K_DYNP}, {8'hE0, fcs_pkg::K_DYNP},
		{8'hFB, fcs_pkg::K_DYNP}, {8'hE1, fcs_pkg::K_DYNP},
		{8'hFC, fcs_pkg::K_PERSP}, {8'hE2, fcs_pkg::K_PERSP},
		{8'hFD, fcs_pkg::K_PERSP}, {8'hE3, fcs_pkg::K_PERSP},
		{8'hE4, fcs_pkg::K_PERSP}, {8'h2B, fcs_pkg::K_SPROT},
		{8'h2F, fcs_pkg::K_SPROT}, {8'hA7, fcs_pkg::K_LOCK},
		{8'hA6, fcs_pkg::K_LOCK}, {8'hE7, fcs_pkg::K_PASSWORD},
		{8'hE8, fcs_pkg::K_PASSWORD}, {8'hE9, fcs_pkg::K_PASSWORD}};

	fcs_ctrl dut (.mclk(mclk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
		.si(si), .so(so), .so_oe(so_oe), .op_busy(op_busy),
		.prog_fail(prog_fail), .erase_fail(erase_fail),
		.cfg_30_clear(cfg_30_clear), .cmd(cmd), .status(status));
	fcs_host h (.mclk(mclk), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(so_oe));

	// ========================================================
	// Clock and command monitor
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	// The valid strobe lasts one cycle; the falling edge sees it settled.
	always @(negedge mclk) begin
		if (cmd.valid === 1'b1) begin
			n_cmd++;
			last_code = cmd.code;
			last_kind = cmd.kind;
		end
	end

	// ========================================================
	// Access tasks
	task automatic op(input logic [7:0] c);
		h.xfer(c, 0, 0, rd);
	endtask

	task automatic rd_st(input logic [7:0] c, input int na,
		input logic [7:0] e);
		h.xfer(c, na, 1, rd);
		`TB_CHECK("status byte", e, rd)
	endtask

	// Order: busy, latch, program error, erase error, suspended, sleep.
	task automatic chk_st(input logic [5:0] e);
		`TB_CHECK("status", e, status)
	endtask

	task automatic fail(input bit prog);
		@(posedge mclk);
		if (prog) prog_fail <= 1'b1;
		else erase_fail <= 1'b1;
		@(posedge mclk);
		prog_fail <= 1'b0;
		erase_fail <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic complete_run;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// A frame lasts at most 5 us and the run about 70 us; 400 us is ample.
	initial begin
		#400000;
		num_errors++;
		complete_run();
	end

	// ========================================================
	// Main sequence
	initial begin
		{reset_n, op_busy, prog_fail, erase_fail, cfg_30_clear} = '0;
		{num_errors, check_count, n_cmd} = '0;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk_st(6'h00);
		rd_st(8'h05, 0, 8'h00);
		op(8'h06);
		rd_st(8'h65, 3, 8'h02);
		op(8'h04);
		chk_st(6'h00);
		op(8'h75);
		`TB_CHECK("idle suspend", 0, n_cmd)
		@(posedge mclk) op_busy <= 1'b1;
		rd_st(8'h05, 0, 8'h01);
		op(8'hB9);
		chk_st(6'h20);
		for (int i = 0; i < 3; i++) begin
			op(SUS[i]);
			chk_st(6'h22);
			`TB_CHECK("suspend code", SUS[i], last_code)
			op(RSM[i]);
			chk_st(6'h20);
			`TB_CHECK("resume code", RSM[i], last_code)
		end
		op(8'h7A);
		`TB_CHECK("cmd count", 6, n_cmd)
		`TB_CHECK("resume kind", fcs_pkg::K_RESUME, last_kind)
		// Byte 30 configured as clear must no longer resume.
		@(posedge mclk) cfg_30_clear <= 1'b1;
		op(8'h75);
		op(8'h30);
		chk_st(6'h22);
		op(8'h7A);
		@(posedge mclk) op_busy <= 1'b0;
		cfg_30_clear <= 1'b0;
		// Program failure with the latch set, then the recovery pair.
		op(8'h06);
		fail(1'b1);
		chk_st(6'h38);
		rd_st(8'h05, 0, 8'h43);
		n_cmd = 0;
		op(8'h04);
		op(8'h75);
		op(8'hB9);
		chk_st(6'h38);
		`TB_CHECK("refused cmd", 0, n_cmd)
		op(8'h30);
		chk_st(6'h10);
		op(8'h04);
		chk_st(6'h00);
		fail(1'b0);
		chk_st(6'h24);
		rd_st(8'h65, 3, 8'h21);
		op(8'h82);
		chk_st(6'h00);
		// Software and hardware reset out of the error state.
		fail(1'b1);
		op(8'h99);
		chk_st(6'h28);
		op(8'h66);
		op(8'h99);
		chk_st(6'h00);
		fail(1'b0);
		op(8'hF0);
		chk_st(6'h00);
		fail(1'b1);
		@(posedge mclk) reset_n <= 1'b0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk_st(6'h00);
		// Deep power-down ignores all but the release byte.
		op(8'hB9);
		chk_st(6'h01);
		op(8'h06);
		chk_st(6'h01);
		op(8'hAB);
		chk_st(6'h00);
		op(8'h06);
		for (int i = 0; i < 19; i++) begin
			op(PT[i][11:4]);
			`TB_CHECK("engine code", PT[i][11:4], last_code)
			`TB_CHECK("engine kind", PT[i][3:0], last_kind)
		end
		complete_run();
	end
endmodule
